// ### hdl/line_cfg_pkg.sv
package line_cfg_pkg;

  // register byte offsets on the host register port
  localparam logic [7:0] ADDR_GEN_CONTROL   = 8'h06;
  localparam logic [7:0] ADDR_MAIN_CONFIG   = 8'h07;
  localparam logic [7:0] ADDR_AUX_CONFIG    = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_CONFIG  = 8'h09;
  localparam logic [7:0] ADDR_CLOCK_TRIM    = 8'h0A;
  localparam logic [7:0] ADDR_REVISION      = 8'h0C;

  // reset values, all fields clear
  localparam logic [7:0] RST_GEN_CONTROL    = 8'h00;
  localparam logic [7:0] RST_LINE_CONFIG    = 8'h00;
  localparam logic [7:0] RST_CLOCK_CONFIG   = 8'h00;
  localparam logic [7:0] RST_CLOCK_TRIM     = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // general control fields
  localparam int BIT_MAIN_SOFT_OUTPUT       = 0;
  localparam int BIT_AUX_SOFT_OUTPUT        = 1;

  // clock config fields
  localparam int BIT_FINE_TRIM_ENABLE       = 7;
  localparam int BIT_CLOCK_DIV_HI           = 2;
  localparam int BIT_CLOCK_DIV_LO           = 1;
  localparam int BIT_CLOCK_OUT_DISABLE      = 0;
  localparam logic [7:0] MASK_CLOCK_CONFIG  = 8'h87;
  localparam logic [7:0] MASK_CLOCK_TRIM    = 8'h3F;

  // divider encodings
  localparam logic [1:0] DIV_3M686          = 2'h0;
  localparam logic [1:0] DIV_7M373          = 2'h1;
  localparam logic [1:0] DIV_14M74          = 2'h2;
  localparam logic [1:0] DIV_1M843          = 2'h3;

  // phase step = f_out / 50 MHz * 2^32
  localparam int unsigned ACC_WIDTH         = 32;
  localparam logic [31:0] INC_3M686         = 32'h12DF_D695;
  localparam logic [31:0] INC_7M373         = 32'h25BF_AD2A;
  localparam logic [31:0] INC_14M74         = 32'h4B7F_5A53;
  localparam logic [31:0] INC_1M843         = 32'h096F_EB4A;

  // trim slope shifts: about 0.02 %/step below zero, 0.2 %/step above
  localparam int TRIM_NEG_SHIFT             = 12;
  localparam int TRIM_POS_SHIFT             = 9;

  // edge rate encodings, typical
  localparam logic [1:0] EDGE_250NS         = 2'h0;
  localparam logic [1:0] EDGE_500NS         = 2'h1;
  localparam logic [1:0] EDGE_1US25         = 2'h2;
  localparam logic [1:0] EDGE_5US           = 2'h3;

  // input synchroniser depth
  localparam int SYNC_STAGES                = 3;

  // driver configuration byte, msb first
  typedef struct packed {
    logic [1:0] edge_rate;
    logic       weak_pulldown_en;
    logic       weak_pullup_en;
    logic       low_side_sel;
    logic       push_pull_sel;
    logic       polarity_same;
    logic       driver_enable;
  } line_cfg_t;

  // what one line driver does with its pin
  typedef struct packed {
    logic       level;
    logic       drive_en;
    logic       weak_pulldown_en;
    logic       weak_pullup_en;
    logic [1:0] edge_rate;
  } line_drive_t;

endpackage

// ### hdl/line_drive_decode.sv
`timescale 1ns/1ns
module line_drive_decode
  import line_cfg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire line_cfg_t   cfg_i,
  input  wire logic        gate_i,
  input  wire logic        data_i,
  input  wire logic        soft_bit_i,
  output line_drive_t      drive_o
);

  logic        pull_low;
  logic        can_sink;
  logic        can_source;
  logic        active;
  line_drive_t next_drive;

  // default polarity is inverting: low only for data high and soft bit 0
  assign pull_low   = cfg_i.polarity_same ^ (data_i & ~soft_bit_i);  // [R5] [R8] [R10]
  assign can_sink   = cfg_i.push_pull_sel | cfg_i.low_side_sel;       // [R4] [R18]
  assign can_source = cfg_i.push_pull_sel | ~cfg_i.low_side_sel;      // [R4] [R18]
  assign active     = cfg_i.driver_enable & gate_i;                   // [R7] [R9]

  assign next_drive.level            = ~pull_low;
  assign next_drive.drive_en         = active & (pull_low ? can_sink : can_source);  // [R8] [R10]
  assign next_drive.weak_pulldown_en = cfg_i.weak_pulldown_en;        // [R2]
  assign next_drive.weak_pullup_en   = cfg_i.weak_pullup_en;          // [R3]
  assign next_drive.edge_rate        = cfg_i.edge_rate;               // [R1]

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      drive_o <= '0;
    end else begin
      drive_o <= next_drive;
    end
  end

endmodule

// ### hdl/line_driver_and_clock_config.sv
// Functional notes
// R1: aux config bits 7:6 pick edge rate 250ns, 500ns, 1.25us, 5us.
// R2: aux config bit 5 enables the weak pull-down sink.
// R3: aux config bit 4 enables the weak pull-up source.
// R4: aux bit 2 gives push-pull; else bit 3 picks low-side or high-side.
// R5: aux bit 1 clear inverts line against local pin and soft bit.
// R6: aux bit 0 enables driver, disables receiver, makes local pin an input.
// R7: aux driver disabled leaves the line undriven whatever the soft bit.
// R8: enabled aux pulls low only for local high, soft 0; else high or Z.
// R9: main line is Z when its enable or transmit enable is low.
// R10: main pulls low only for transmit high, soft 0; else high or Z.
// R11: clock config bit 7 enables fine trimming of the clock output.
// R12: clock bits 2:1 select 3.686, 7.373, 14.74 or 1.843 MHz.
// R13: clock bit 0 stops the clock output but keeps the pin driven.
// R14: trim bits 5:0 signed, +0.7% at -32 down to -5.5% at +31.
// R15: eight-bit read-only revision identifier; writes do nothing.
// R16: after reset the clock output runs at 3.686 MHz unprompted.
// R17: general control bit 0 is main soft bit, bit 1 aux soft bit.
// R18: main topology from its config bits 3 and 2 like the aux driver.
// R19: trim value applies only while fine trimming is enabled.
// R20: reserved clock config and trim bits read zero, ignore writes.
`timescale 1ns/1ns
module line_driver_and_clock_config
  import line_cfg_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5A  // arbitrary value
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic        transmit_enable_in_i,
  input  wire logic        transmit_data_i,
  input  wire logic        main_line_i,
  output logic             main_line_o,
  output logic             main_line_oe_o,
  output logic             main_rx_o,
  output logic             main_weak_pulldown_en_o,
  output logic             main_weak_pullup_en_o,
  output logic [1:0]       main_edge_rate_o,
  input  wire logic        aux_line_i,
  output logic             aux_line_o,
  output logic             aux_line_oe_o,
  output logic             aux_receiver_en_o,
  output logic             aux_weak_pulldown_en_o,
  output logic             aux_weak_pullup_en_o,
  output logic [1:0]       aux_edge_rate_o,
  input  wire logic        aux_local_logic_pin_i,
  output logic             aux_local_logic_pin_o,
  output logic             aux_local_logic_pin_oe_o,
  output logic             clock_out_o
);

  localparam int NUM_PINS = 5;

  // pin indices in the synchroniser bank
  localparam int PIN_TRANSMIT_ENABLE_IN  = 0;
  localparam int PIN_TXD   = 1;
  localparam int PIN_MAIN  = 2;
  localparam int PIN_AUX   = 3;
  localparam int PIN_LOCAL = 4;

  function automatic logic [31:0] base_increment(input logic [1:0] div);
    logic [31:0] inc;
    inc = INC_3M686;
    case (div)
      DIV_3M686: inc = INC_3M686;
      DIV_7M373: inc = INC_7M373;
      DIV_14M74: inc = INC_14M74;
      DIV_1M843: inc = INC_1M843;
      default:   inc = INC_3M686;
    endcase
    return inc;
  endfunction

  // trim is asymmetric: a fine slope upward, a coarse slope downward
  function automatic logic [31:0] trimmed_increment(input logic [31:0] base, input logic [5:0] trim);
    logic [31:0] mag;
    logic [31:0] step;
    mag  = {26'h0, (trim[5] ? 6'(-trim) : trim)};
    step = trim[5] ? (base >> TRIM_NEG_SHIFT) : (base >> TRIM_POS_SHIFT);
    return trim[5] ? 32'(base + step * mag) : 32'(base - step * mag);  // [R14]
  endfunction

  logic [7:0]          gen_control;
  line_cfg_t           main_config;
  line_cfg_t           aux_config;
  logic [7:0]          clock_config;
  logic [7:0]          clock_trim;

  logic [NUM_PINS-1:0] sync_s0;
  logic [NUM_PINS-1:0] sync_s1;
  logic [NUM_PINS-1:0] sync_s2;
  logic [NUM_PINS-1:0] pin_q;
  logic [NUM_PINS-1:0] next_pin_q;

  logic [31:0]         phase_acc;
  logic [31:0]         base_inc;
  logic [31:0]         phase_inc;
  logic                next_clock_out;
  logic [7:0]          next_rdata;

  logic                wr_gen;
  logic                wr_main;
  logic                wr_aux;
  logic                wr_clock;
  logic                wr_trim;

  line_drive_t         main_drive;
  line_drive_t         aux_drive;
  logic                aux_rx_level;

  // register write decode
  assign wr_gen   = reg_wr_i & (reg_addr_i == ADDR_GEN_CONTROL);
  assign wr_main  = reg_wr_i & (reg_addr_i == ADDR_MAIN_CONFIG);
  assign wr_aux   = reg_wr_i & (reg_addr_i == ADDR_AUX_CONFIG);
  assign wr_clock = reg_wr_i & (reg_addr_i == ADDR_CLOCK_CONFIG);
  assign wr_trim  = reg_wr_i & (reg_addr_i == ADDR_CLOCK_TRIM);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gen_control  <= RST_GEN_CONTROL;
      main_config  <= RST_LINE_CONFIG;
      aux_config   <= RST_LINE_CONFIG;
      clock_config <= RST_CLOCK_CONFIG;
      clock_trim   <= RST_CLOCK_TRIM;
    end else begin
      if (wr_gen) begin
        gen_control <= reg_wdata_i;                          // [R17]
      end
      if (wr_main) begin
        main_config <= reg_wdata_i;                          // [R18]
      end
      if (wr_aux) begin
        aux_config <= reg_wdata_i;                           // [R1] [R2] [R3] [R4] [R5] [R6]
      end
      if (wr_clock) begin
        clock_config <= reg_wdata_i & MASK_CLOCK_CONFIG;     // [R11] [R12] [R13] [R20]
      end
      if (wr_trim) begin
        clock_trim <= reg_wdata_i & MASK_CLOCK_TRIM;         // [R14] [R20]
      end
    end
  end

  // read mux; the revision address has no write decode at all
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_GEN_CONTROL:  next_rdata = gen_control;
        ADDR_MAIN_CONFIG:  next_rdata = main_config;
        ADDR_AUX_CONFIG:   next_rdata = aux_config;
        ADDR_CLOCK_CONFIG: next_rdata = clock_config;
        ADDR_CLOCK_TRIM:   next_rdata = clock_trim;
        ADDR_REVISION:     next_rdata = REVISION_ID;        // [R15]
        default:           next_rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= READ_UNMAPPED;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // pins pass three stages; a change counts once stages two and three agree
  assign next_pin_q = (sync_s1 & sync_s2) | (pin_q & (sync_s1 | sync_s2));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync_s0 <= '0;
      sync_s1 <= '0;
      sync_s2 <= '0;
      pin_q   <= '0;
    end else begin
      sync_s0 <= {aux_local_logic_pin_i, aux_line_i, main_line_i, transmit_data_i, transmit_enable_in_i};
      sync_s1 <= sync_s0;
      sync_s2 <= sync_s1;
      pin_q   <= next_pin_q;
    end
  end

  line_drive_decode main_decode (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .cfg_i      (main_config),
    .gate_i     (pin_q[PIN_TRANSMIT_ENABLE_IN]),                           // [R9]
    .data_i     (pin_q[PIN_TXD]),
    .soft_bit_i (gen_control[BIT_MAIN_SOFT_OUTPUT]),         // [R17]
    .drive_o    (main_drive)
  );

  line_drive_decode aux_decode (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .cfg_i      (aux_config),
    .gate_i     (1'b1),
    .data_i     (pin_q[PIN_LOCAL]),
    .soft_bit_i (gen_control[BIT_AUX_SOFT_OUTPUT]),          // [R17]
    .drive_o    (aux_drive)
  );

  assign main_line_o             = main_drive.level;
  assign main_line_oe_o          = main_drive.drive_en;
  assign main_weak_pulldown_en_o = main_drive.weak_pulldown_en;
  assign main_weak_pullup_en_o   = main_drive.weak_pullup_en;
  assign main_edge_rate_o        = main_drive.edge_rate;

  assign aux_line_o              = aux_drive.level;
  assign aux_line_oe_o           = aux_drive.drive_en;
  assign aux_weak_pulldown_en_o  = aux_drive.weak_pulldown_en;
  assign aux_weak_pullup_en_o    = aux_drive.weak_pullup_en;
  assign aux_edge_rate_o         = aux_drive.edge_rate;

  // receivers follow the same polarity as the drivers
  assign aux_rx_level = pin_q[PIN_AUX] ^ ~aux_config.polarity_same;  // [R5]

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      main_rx_o                <= 1'b0;
      aux_receiver_en_o        <= 1'b0;
      aux_local_logic_pin_o    <= 1'b0;
      aux_local_logic_pin_oe_o <= 1'b0;
    end else begin
      main_rx_o                <= pin_q[PIN_MAIN] ^ ~main_config.polarity_same;
      aux_receiver_en_o        <= ~aux_config.driver_enable;                           // [R6]
      aux_local_logic_pin_o    <= aux_rx_level & ~aux_config.driver_enable;
      aux_local_logic_pin_oe_o <= ~aux_config.driver_enable;                           // [R6]
    end
  end

  // clock output: phase accumulator, msb is the square wave
  assign base_inc  = base_increment(clock_config[BIT_CLOCK_DIV_HI:BIT_CLOCK_DIV_LO]);  // [R12] [R16]
  assign phase_inc = clock_config[BIT_FINE_TRIM_ENABLE] ?
                     trimmed_increment(base_inc, clock_trim[5:0]) : base_inc;          // [R11] [R19]
  // disabled output is held low and still driven, never floated
  assign next_clock_out = ~clock_config[BIT_CLOCK_OUT_DISABLE] & phase_acc[ACC_WIDTH-1];  // [R13]

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      phase_acc   <= '0;
      clock_out_o <= 1'b0;
    end else begin
      phase_acc   <= phase_acc + phase_inc;                  // [R16]
      clock_out_o <= next_clock_out;
    end
  end

endmodule

// ### dv/line_cfg_properties.sv
`timescale 1ns/1ns
module line_cfg_checker
  import line_cfg_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5A  // arbitrary value
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       transmit_enable_in_i,
  input  wire logic       main_line_oe_o,
  input  wire logic       aux_line_oe_o,
  input  wire logic       aux_receiver_en_o,
  input  wire logic       aux_local_logic_pin_oe_o,
  input  wire logic [1:0] aux_edge_rate_o,
  input  wire logic       clock_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic clk_off;
  wire  wr_aux   = reg_wr_i && reg_addr_i == ADDR_AUX_CONFIG;
  wire  wr_clk   = reg_wr_i && reg_addr_i == ADDR_CLOCK_CONFIG;
  wire  unmapped = !(reg_addr_i inside {[ADDR_GEN_CONTROL:ADDR_CLOCK_TRIM], ADDR_REVISION});
  // shadow of the stop bit with the register's own lag
  always_ff @(posedge clock_i) begin
    clk_off <= sys_rst_i ? 1'b0 : wr_clk ? reg_wdata_i[BIT_CLOCK_OUT_DISABLE] : clk_off;
  end
  edge_rate_copy_a: assert property (wr_aux |-> ##2 aux_edge_rate_o == $past(reg_wdata_i[7:6], 2))
    else $error("edge rate output does not follow the aux config write");
  rx_enable_follow_a: assert property (wr_aux |-> ##2 aux_receiver_en_o == !$past(reg_wdata_i[0], 2)
    && aux_local_logic_pin_oe_o == !$past(reg_wdata_i[0], 2)) else $error("receiver or local pin direction wrong");
  aux_idle_undriven_a: assert property (aux_receiver_en_o |-> !aux_line_oe_o)
    else $error("aux line driven while its driver is off");
  main_transmit_enable_in_low_a: assert property (!transmit_enable_in_i [*7] |-> !main_line_oe_o)
    else $error("main line driven with transmit enable low");
  rev_read_a: assert property (reg_rd_i && reg_addr_i == ADDR_REVISION |=> reg_rdata_o == REVISION_ID)
    else $error("revision read wrong");
  clk_reserved_a: assert property (reg_rd_i && reg_addr_i == ADDR_CLOCK_CONFIG |=> reg_rdata_o[6:3] == 4'h0)
    else $error("clock config reserved bits not zero");
  trim_reserved_a: assert property (reg_rd_i && reg_addr_i == ADDR_CLOCK_TRIM |=> reg_rdata_o[7:6] == 2'h0)
    else $error("trim reserved bits not zero");
  unmapped_read_a: assert property (reg_rd_i && unmapped |=> reg_rdata_o == READ_UNMAPPED)
    else $error("unmapped read not zero");
  clk_stopped_a: assert property (clk_off && $past(clk_off) |-> !clock_out_o)
    else $error("clock output runs while stopped");
  clk_starts_a: assert property ($fell(sys_rst_i) |-> ##[1:24] $rose(clock_out_o))
    else $error("clock output idle after reset");
  clk_high_bound_a: assert property ($rose(clock_out_o) |-> ##[1:16] !clock_out_o)
    else $error("clock output high too long");
endmodule

// ### dv/line_far_end.sv
`timescale 1ns/1ns
module line_far_end (
  input  wire logic        clock_i,
  input  wire logic        main_oe_i,
  input  wire logic        main_lvl_i,
  input  wire logic        aux_oe_i,
  input  wire logic        aux_lvl_i,
  input  wire logic        aux_pd_i,
  input  wire logic        aux_pu_i,
  input  wire logic        far_i,
  input  wire logic        mclk_i,
  output logic             main_line_o,
  output logic             aux_line_o,
  output logic [15:0]      rises_o
);
  logic mclk_q = 1'b0;
  // released main line never keeps its last level: the master keeps toggling it; released aux line too, unless a weak pull holds it
  assign main_line_o = main_oe_i ? main_lvl_i : far_i;
  assign aux_line_o  = aux_oe_i ? aux_lvl_i : aux_pu_i ? 1'b1 : aux_pd_i ? 1'b0 : ~far_i;
  initial rises_o = 16'h0000;
  always @(posedge clock_i) begin
    mclk_q <= mclk_i;
    if (mclk_i && !mclk_q) rises_o <= rises_o + 16'h0001;
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import line_cfg_pkg::*;
  localparam logic [7:0] REV = 8'hC3;  // arbitrary value
  logic       clock_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic       transmit_enable_in = 1'b0, txd = 1'b0, pin = 1'b0, far = 1'b0, pin_req = 1'b0, rd_q = 1'b0, pn_q = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rdata, rq[$], pq[$];
  logic       main_oe, main_lvl, aux_oe, aux_lvl, rx_en, loc_oe, pd, pu, mclk, main_ln, aux_ln;
  logic       mpd, mpu, mrx, lout;
  logic [1:0] medge, aedge;
  logic [15:0] rises;
  logic [7:0] addrs[8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'hFF};
  int         failures = 0, n_checks = 0, seed = 32'hEAD3;

  line_driver_and_clock_config #(.REVISION_ID(REV)) DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .transmit_enable_in_i(transmit_enable_in),
    .transmit_data_i(txd), .main_line_i(main_ln), .main_line_o(main_lvl), .main_line_oe_o(main_oe),
    .main_rx_o(mrx), .main_weak_pulldown_en_o(mpd), .main_weak_pullup_en_o(mpu), .main_edge_rate_o(medge),
    .aux_line_i(aux_ln), .aux_line_o(aux_lvl), .aux_line_oe_o(aux_oe), .aux_receiver_en_o(rx_en),
    .aux_weak_pulldown_en_o(pd), .aux_weak_pullup_en_o(pu), .aux_edge_rate_o(aedge),
    .aux_local_logic_pin_i(pin), .aux_local_logic_pin_o(lout), .aux_local_logic_pin_oe_o(loc_oe), .clock_out_o(mclk));
  line_far_end far_end (
    .clock_i(clock_i), .main_oe_i(main_oe), .main_lvl_i(main_lvl), .aux_oe_i(aux_oe), .aux_lvl_i(aux_lvl),
    .aux_pd_i(pd), .aux_pu_i(pu), .far_i(far), .mclk_i(mclk), .main_line_o(main_ln), .aux_line_o(aux_ln),
    .rises_o(rises));

  always #10 clock_i = ~clock_i;
  always @(negedge clock_i) far <= ~far;

  task automatic results();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic pins(input logic [15:0] e);
    pq.push_back(e[15:8]);
    pq.push_back(e[7:0]);
    @(negedge clock_i);
    pin_req = 1'b1;
    @(negedge clock_i);
    pin_req = 1'b0;
  endtask
  // clock output edges over 2000 cycles, checked against a window
  task automatic freq(input logic [7:0] cc, input logic [7:0] tr, input int lo, input int hi);
    logic [15:0] r0;
    wr(ADDR_CLOCK_TRIM, tr);
    wr(ADDR_CLOCK_CONFIG, cc);
    repeat (40) @(negedge clock_i);
    r0 = rises;
    repeat (2000) @(negedge clock_i);
    r0 = rises - r0;
    cmp({7'h00, r0 >= lo && r0 <= hi}, 8'h01);
  endtask

  always @(posedge clock_i) begin
    rd_q <= reg_rd_i;
    pn_q <= pin_req;
  end
  always @(negedge clock_i) begin
    if (rd_q) cmp(rdata, rq.pop_front());
    if (pn_q) begin
      cmp({main_oe & main_lvl, main_oe, aux_oe & aux_lvl, aux_oe, rx_en, loc_oe, pd, pu}, pq.pop_front());
      cmp({mpd, mpu, medge, aedge, mrx & main_oe, lout & ~rx_en}, pq.pop_front());
    end
  end

  initial begin
    logic [7:0]  c, m;
    logic [31:0] s;
    logic        pa, pm, oa, om;
    repeat (6) @(negedge clock_i);
    sys_rst_i = 1'b0;
    foreach (addrs[i]) rd(addrs[i], addrs[i] == 8'h0C ? REV : 8'h00);
    wr(ADDR_REVISION, ~REV);
    rd(ADDR_REVISION, REV);
    repeat (6) begin
      c = $random(seed);
      wr(ADDR_CLOCK_CONFIG, c);
      wr(ADDR_CLOCK_TRIM, c);
      wr(ADDR_AUX_CONFIG, c);
      rd(ADDR_CLOCK_CONFIG, c & 8'h87);
      rd(ADDR_CLOCK_TRIM, c & 8'h3F);
      rd(ADDR_AUX_CONFIG, c);
    end
    for (int k = 0; k < 64; k++) begin
      c = $random(seed);
      m = $random(seed);
      s = $random(seed);
      c[3:0] = k[3:0];
      m[3:0] = k[5:2];
      wr(ADDR_AUX_CONFIG, c);
      wr(ADDR_MAIN_CONFIG, m);
      wr(ADDR_GEN_CONTROL, {6'h00, k[5], s[2]});
      pin = k[4];
      txd = s[0];
      transmit_enable_in = s[1] | k[0];
      // driven line must pass back through the receiver synchroniser too
      repeat (10) @(negedge clock_i);
      pa = c[1] ^ (k[4] & ~k[5]);
      pm = m[1] ^ (txd & ~s[2]);
      oa = c[0] & (pa ? (c[2] | c[3]) : (c[2] | ~c[3]));
      om = m[0] & transmit_enable_in & (pm ? (m[2] | m[3]) : (m[2] | ~m[3]));
      pins({om & ~pm, om, oa & ~pa, oa, ~c[0], ~c[0], c[5], c[4],
            m[5], m[4], m[7:6], c[7:6], om & txd & ~s[2], 1'b0});
    end
    freq(8'h00, 8'h00, 146, 149);
    freq(8'h02, 8'h00, 293, 296);
    freq(8'h04, 8'h00, 588, 591);
    freq(8'h06, 8'h00, 72, 75);
    freq(8'h84, 8'h20, 592, 599);
    freq(8'h84, 8'h1F, 540, 585);
    freq(8'h04, 8'h1F, 588, 591);
    freq(8'h01, 8'h00, 0, 0);
    repeat (3) @(negedge clock_i);
    results();
  end

  // whole run is about 17600 cycles
  initial begin
    repeat (40000) @(posedge clock_i);
    failures++;
    results();
  end
endmodule

bind line_driver_and_clock_config line_cfg_checker #(.REVISION_ID(REVISION_ID)) u_chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .transmit_enable_in_i(transmit_enable_in_i), .main_line_oe_o(main_line_oe_o), .aux_line_oe_o(aux_line_oe_o),
  .aux_receiver_en_o(aux_receiver_en_o), .aux_local_logic_pin_oe_o(aux_local_logic_pin_oe_o),
  .aux_edge_rate_o(aux_edge_rate_o), .clock_out_o(clock_out_o));
